// >>> include/strap_pins_pkg.sv
/*
  Package for the strap and port power pin logic: pin function codes,
  strap and pin drive carriers, timing counts.
  Assumes a 250 MHz system clock.
*/
package strap_pins_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned STRAP_HOLD_NS  = 3000;
  localparam int unsigned STRAP_HOLD_CYC = (STRAP_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_W         = 10;
  localparam int unsigned NRD_RST_CYC    = 16;
  localparam int unsigned NRD_RST_W      = 5;

  // ---------------------------------------------------------------
  // Pin function and phase codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCLK_HIZ   = 2'h0,
    SCLK_CLOCK = 2'h1,
    SCLK_SUSP  = 2'h2,
    SCLK_DOCK  = 2'h3
  } sclk_fn_t;

  typedef enum logic [1:0] {
    IND_HIZ   = 2'h0,
    IND_SUSP  = 2'h1,
    IND_DOCK  = 2'h2,
    IND_RSVD  = 2'h3
  } ind_fn_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'h0,
    ST_HOLD  = 2'h1,
    ST_RUN   = 2'h2
  } phase_t;

  // Latched strap levels
  typedef struct packed {
    logic rom_select;
    logic oc_port1;
    logic oc_port2;
    logic ind_port1;
    logic ind_port2;
    logic pwr_port1;
    logic pwr_port2;
  } strap_t;

  // Open-drain / tristate pin drive
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drv_t;

endpackage : strap_pins_pkg

// >>> rtl/clock_divider.sv
/*
  Compound-device clock generator: a divided clock at 24 or 12 MHz
  equivalent rate from the system clock.
  Assumes divider limits fit in the counter width.
*/
`timescale 1ns/10ps
module clock_divider #(
  parameter int unsigned     CNT_W  = 4,
  parameter logic [3:0]      HALF_F = 4'h5,   // Half period, fast rate
  parameter logic [3:0]      HALF_S = 4'hA    // Half period, slow rate
) (
  input  wire logic sys_clk_i,   // System clock
  input  wire logic srst_i,      // Sync reset
  input  wire logic run_i,       // Enable output clock
  input  wire logic slow_i,      // Select slow rate
  output logic      clk_o        // Divided clock, registered
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             clk;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;

  // Counter toggles the output every half period
  always_comb begin
    s_d = s_q;
    if (!run_i) begin
      s_d.cnt = '0;
      s_d.clk = 1'b0;
    end else if (s_q.cnt >= CNT_W'((slow_i ? HALF_S : HALF_F) - 4'h1)) begin
      s_d.cnt = '0;
      s_d.clk = ~s_q.clk;
    end else begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_o = s_q.clk;

endmodule : clock_divider

// >>> rtl/strap_pins.sv
/*
  Strap capture and shared pin function logic for a two-port hub:
  suspend/clock pin, indicator pin, port power enables, compound reset,
  over-current and power sensing.
  Assumes pins are already synchronous to sys_clk_i; chip reset is
  synchronous and active high here (inverted from the board pin).
  The compound clock is an integer division of the system clock,
  so its rates are the nearest ones the divider reaches.
  Pins are level/enable pairs; pads and pull resistors sit outside.
  Straps are taken once, on the first edge after reset ends.
  Over-current on a non-removable port is ignored.
  Ganged power uses request bit 0 for both ports.
*/
// Contract
// - Latch all strap levels when reset ends; they fix configuration.
// - Strap pins stay inputs during reset and 3 us after.
// - Suspend function drives 1 in suspend, 0 otherwise.
// - Suspend/clock pin high impedance until its function is set.
// - ROM absent: port-1 OC strap picks clock/suspend; indicator low gives dock.
// - ROM present: ROM picks clock or suspend, never dock.
// - Dock mode: suspend/clock pin is active-low open-drain VBUS control.
// - Compound clock output selectable 24 or 12 MHz.
// - Upstream bus power sense is active high.
// - Local power sense copied continuously to self-powered status.
// - ROM suspend enable drives indicator pin as suspend, else Hi-Z.
// - Dock mode drives indicator pin as push-pull ID control; one combo reserved.
// - Over-current inputs are active low.
// - OC strap high gives removable port, low non-removable.
// - Port-1 power strap high gives power enable, low compound reset.
// - Power enables open-drain, low turns VBUS on.
// - Port-2 power strap high individual, low ganged control.
`timescale 1ns/10ps
module strap_pins
  import strap_pins_pkg::*;
(
  input  wire logic       sys_clk_i,            // System clock
  input  wire logic       srst_i,               // Chip reset, active high
  // Strap and pin inputs
  input  wire logic       rom_select_strap_i,   // ROM select strap level
  input  wire logic       overcurrent_in_port1_i, // Port 1 OC, active low
  input  wire logic       overcurrent_in_port2_i, // Port 2 OC, active low
  input  wire logic       indicator_pin_port1_i,  // Indicator/suspend pin level
  input  wire logic       indicator_pin_port2_i,  // Port 2 indicator strap
  input  wire logic       power_enable_port1_n_i, // Port 1 power pin level
  input  wire logic       power_enable_port2_n_i, // Port 2 power pin level
  input  wire logic       upstream_bus_power_sense_i, // Upstream VBUS present
  input  wire logic       local_power_sense_i,  // Local power supplied
  // Hub core side
  input  wire logic       suspended_i,          // Hub in suspend
  input  wire logic       rom_use_clock_i,      // ROM: pin is compound clock
  input  wire logic       rom_suspend_en_i,     // ROM: suspend on indicator pin
  input  wire logic       clock_slow_i,         // Compound clock 12 MHz select
  input  wire logic [1:0] port_power_req_i,     // Core asks port power on
  input  wire logic       dock_vbus_on_i,       // Dock VBUS control request
  input  wire logic       dock_id_on_i,         // Dock ID resistor request
  input  wire logic       compound_reset_req_i, // Core asks compound reset
  // Suspend/clock shared pin
  output logic            susp_clk_o,           // Pin output level
  output logic            susp_clk_oe_o,        // Pin output enable
  // Indicator/suspend pin
  output logic            ind_pin_o,            // Pin output level
  output logic            ind_pin_oe_o,         // Pin output enable
  // Port power pins (port 1 doubles as compound reset)
  output logic            power_enable_port1_n_o,  // Pin level
  output logic            power_enable_port1_n_oe_o, // Pin enable
  output logic            power_enable_port2_n_o,  // Pin level
  output logic            power_enable_port2_n_oe_o, // Pin enable
  // Status to hub core
  output logic            compound_clock_out_o, // Compound clock, direct
  output logic            self_powered_o,       // Device status bit
  output logic            upstream_present_o,   // Upstream VBUS present
  output logic [1:0]      overcurrent_o,        // OC state per port
  output logic [1:0]      overcurrent_event_o,  // OC start pulse per port
  output logic [1:0]      removable_o,          // Port removable
  output logic            individual_power_o,   // Individual power mode
  output logic            config_done_o         // Straps latched, pins live
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    // Sequencing
    phase_t          phase;
    logic [HOLD_W-1:0] hold;
    // Latched configuration
    strap_t          strap;
    sclk_fn_t        sclk_fn;
    ind_fn_t         ind_fn;
    // Over-current and power
    logic [1:0]      oc_act;
    logic [1:0]      oc_evt;
    logic [1:0]      pwr_on;
    logic [NRD_RST_W-1:0] nrd_cnt;
    // Registered pin drive
    pin_drv_t        sclk;
    pin_drv_t        ind;
    pin_drv_t        pw1;
    pin_drv_t        pw2;
    // Status copies
    logic            self_pwr;
    logic            up_pwr;
    logic            done;
  } state_t;

  // Registered state and its next value
  state_t s_q;
  state_t s_d;
  // Divider output, masked fault levels
  logic   div_clk;
  logic [1:0] oc_now;

  // ---------------------------------------------------------------
  // Over-current decode
  // ---------------------------------------------------------------
  // Active-low over-current inputs, masked for non-removable ports
  function automatic logic oc_seen(input logic pin, input logic removable);
    oc_seen = removable & ~pin;
  endfunction : oc_seen

  // Bit 1 is port 2, bit 0 is port 1
  assign oc_now = {oc_seen(overcurrent_in_port2_i, s_q.strap.oc_port2),
                   oc_seen(overcurrent_in_port1_i, s_q.strap.oc_port1)};

  // ---------------------------------------------------------------
  // Compound clock
  // ---------------------------------------------------------------
  // Runs only while the shared pin carries the clock
  // Half periods: 5 cycles fast, 10 cycles slow
  clock_divider #(
    .CNT_W  (4),
    .HALF_F (4'h5),
    .HALF_S (4'hA)
  ) u_clock_divider (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .run_i     (s_q.sclk_fn == SCLK_CLOCK),
    .slow_i    (clock_slow_i),
    .clk_o     (div_clk)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Defaults hold state; status copies track pins
  always_comb begin
    s_d          = s_q;
    // Event pulses clear unless set again
    s_d.oc_evt   = 2'h0;
    s_d.self_pwr = local_power_sense_i;
    s_d.up_pwr   = upstream_bus_power_sense_i;

    case (s_q.phase)
      // First cycle after reset: catch straps
      ST_RESET: begin
        s_d.strap.rom_select = rom_select_strap_i;
        s_d.strap.oc_port1   = overcurrent_in_port1_i;
        s_d.strap.oc_port2   = overcurrent_in_port2_i;
        // Indicator straps pick dock and reserved modes
        s_d.strap.ind_port1  = indicator_pin_port1_i;
        s_d.strap.ind_port2  = indicator_pin_port2_i;
        s_d.strap.pwr_port1  = power_enable_port1_n_i;
        s_d.strap.pwr_port2  = power_enable_port2_n_i;
        s_d.hold  = '0;
        s_d.phase = ST_HOLD;
      end

      // Drivers kept off for the strap hold time
      ST_HOLD: begin
        if (s_q.hold >= HOLD_W'(STRAP_HOLD_CYC - 1)) begin
          // Hold over: fix functions, start compound reset
          s_d.phase = ST_RUN;
          s_d.done  = 1'b1;
          s_d.nrd_cnt = NRD_RST_W'(NRD_RST_CYC);
          // Suspend/clock pin function
          if (!s_q.strap.rom_select) begin
            if (!s_q.strap.ind_port1) begin
              s_d.sclk_fn = SCLK_DOCK;
            end else if (!s_q.strap.oc_port1) begin
              s_d.sclk_fn = SCLK_CLOCK;
            end else begin
              s_d.sclk_fn = SCLK_SUSP;
            end
          end else begin
            // ROM chooses; dock is never offered here
            s_d.sclk_fn = rom_use_clock_i ? SCLK_CLOCK : SCLK_SUSP;
          end

          // Indicator pin function
          if (!s_q.strap.rom_select && !s_q.strap.ind_port1) begin
            s_d.ind_fn = IND_DOCK;
          end else if (s_q.strap.rom_select && !s_q.strap.ind_port2) begin
            s_d.ind_fn = IND_RSVD;
          end else if (s_q.strap.rom_select && rom_suspend_en_i) begin
            s_d.ind_fn = IND_SUSP;
          end else begin
            s_d.ind_fn = IND_HIZ;
          end
        end else begin
          // Still counting out the hold time
          s_d.hold = s_q.hold + HOLD_W'(1);
        end
      end

      // Functional operation
      ST_RUN: begin
        // Compound reset pulse counts down
        if (s_q.nrd_cnt != '0) begin
          s_d.nrd_cnt = s_q.nrd_cnt - NRD_RST_W'(1);
        end

        // Over-current: cut power, report rising edge
        s_d.oc_act = oc_now;
        s_d.oc_evt = oc_now & ~s_q.oc_act;
        // Individual: each port cut by its own fault
        if (s_q.strap.pwr_port2) begin
          s_d.pwr_on = port_power_req_i & ~oc_now;
        end else begin
          // Ganged: bit 0 drives both, any fault cuts both
          s_d.pwr_on = (|oc_now) ? 2'h0 : {2{port_power_req_i[0]}};
        end
      end

      // Unused phase code: back to strap capture
      default: begin
        s_d.phase = ST_RESET;
      end
    endcase

    // Pin drivers, all off until configured
    s_d.sclk = '0;
    s_d.ind  = '0;
    s_d.pw1  = '0;
    s_d.pw2  = '0;
    if (s_q.phase == ST_RUN) begin
      // Clock, suspend or dock VBUS on the shared pin
      case (s_q.sclk_fn)
        SCLK_CLOCK: s_d.sclk = '{o: div_clk, oe: 1'b1};
        SCLK_SUSP:  s_d.sclk = '{o: suspended_i, oe: 1'b1};
        SCLK_DOCK:  s_d.sclk = '{o: 1'b0, oe: dock_vbus_on_i};
        default:    s_d.sclk = '0;
      endcase

      // Suspend or dock ID control on the indicator pin
      case (s_q.ind_fn)
        IND_SUSP: s_d.ind = '{o: suspended_i, oe: 1'b1};
        IND_DOCK: s_d.ind = '{o: dock_id_on_i, oe: 1'b1};
        default:  s_d.ind = '0;
      endcase
      // Port 1: open-drain power enable or push-pull compound reset
      if (s_q.strap.pwr_port1) begin
        s_d.pw1 = '{o: 1'b0, oe: s_q.pwr_on[0]};
      end else begin
        s_d.pw1 = '{o: ~(compound_reset_req_i | (s_q.nrd_cnt != '0)), oe: 1'b1};
      end

      // Port 2: open-drain power enable only
      s_d.pw2 = '{o: 1'b0, oe: s_q.pwr_on[1]};
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Register all state; reset puts pins back to strap sampling
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Shared pin drive pairs
  assign susp_clk_o                = s_q.sclk.o;
  assign susp_clk_oe_o             = s_q.sclk.oe;
  assign ind_pin_o                 = s_q.ind.o;
  assign ind_pin_oe_o              = s_q.ind.oe;

  // Port power pin drive pairs
  assign power_enable_port1_n_o    = s_q.pw1.o;
  assign power_enable_port1_n_oe_o = s_q.pw1.oe;
  assign power_enable_port2_n_o    = s_q.pw2.o;
  assign power_enable_port2_n_oe_o = s_q.pw2.oe;

  // Clock, status and latched configuration
  assign compound_clock_out_o      = div_clk;
  assign self_powered_o            = s_q.self_pwr;
  assign upstream_present_o        = s_q.up_pwr;
  assign overcurrent_o             = s_q.oc_act;
  assign overcurrent_event_o       = s_q.oc_evt;
  assign removable_o               = {s_q.strap.oc_port2, s_q.strap.oc_port1};
  assign individual_power_o        = s_q.strap.pwr_port2;
  assign config_done_o             = s_q.done;

endmodule : strap_pins

// >>> bench/strap_pins_assertions.sv
/* Checker for strap_pins: pin enables, status copies, over-current, clock.
   Assumes bind to strap_pins, sys_clk_i clock, srst_i sync reset. */
`timescale 1ns/10ps
module strap_pins_assertions (
  input wire logic       sys_clk_i,                  // Clock
  input wire logic       srst_i,                     // Reset
  input wire logic       local_power_sense_i,        // Local power
  input wire logic       upstream_bus_power_sense_i, // VBUS sense
  input wire logic       clock_slow_i,               // Slow rate
  input wire logic       susp_clk_oe_o,              // Pin enable
  input wire logic       ind_pin_oe_o,               // Pin enable
  input wire logic       power_enable_port1_n_oe_o,  // Pin enable
  input wire logic       power_enable_port2_n_o,     // Pin level
  input wire logic       power_enable_port2_n_oe_o,  // Pin enable
  input wire logic       compound_clock_out_o,       // Clock out
  input wire logic       self_powered_o,             // Status
  input wire logic       upstream_present_o,         // Status
  input wire logic [1:0] overcurrent_o,              // OC level
  input wire logic [1:0] overcurrent_event_o,        // OC pulse
  input wire logic [1:0] removable_o,                // Removable
  input wire logic       individual_power_o,         // Power mode
  input wire logic       config_done_o               // Pins live
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // ---------------------------------------------------------------
  // Pin and status checks
  // ---------------------------------------------------------------
  pins_quiet_a: assert property (!config_done_o |-> !(susp_clk_oe_o | ind_pin_oe_o |
    power_enable_port1_n_oe_o | power_enable_port2_n_oe_o)) else $error("pin driven early");
  self_pwr_a: assert property ($past(config_done_o) |->
    self_powered_o == $past(local_power_sense_i)) else $error("self powered stale");
  up_pwr_a: assert property ($past(config_done_o) |->
    upstream_present_o == $past(upstream_bus_power_sense_i)) else $error("vbus sense stale");
  strap_lock_a: assert property (config_done_o && $past(config_done_o) |->
    $stable({removable_o, individual_power_o})) else $error("strap config moved");
  oc_fixed_a: assert property ((overcurrent_o & ~removable_o) == 2'h0)
    else $error("oc on fixed port");
  oc_pulse_a: assert property (overcurrent_event_o != 2'h0 |=>
    (overcurrent_event_o & $past(overcurrent_event_o)) == 2'h0) else $error("oc pulse long");
  oc_cut_a: assert property ((overcurrent_o[1] | (overcurrent_o[0] & !individual_power_o))
    |=> !(power_enable_port2_n_oe_o & !power_enable_port2_n_o)) else $error("oc no cut");
  drain_only_a: assert property (power_enable_port2_n_oe_o |-> !power_enable_port2_n_o)
    else $error("enable driven high");
  clk_fast_a: assert property ($rose(compound_clock_out_o) && !clock_slow_i |->
    compound_clock_out_o [*5] ##1 !compound_clock_out_o) else $error("fast clock width");
  clk_slow_a: assert property ($rose(compound_clock_out_o) && clock_slow_i |->
    ##9 compound_clock_out_o ##1 !compound_clock_out_o) else $error("slow clock width");
  cfg_c: cover property ($rose(config_done_o));
  oc_c: cover property (overcurrent_event_o[1]);
  slow_c: cover property ($rose(compound_clock_out_o) && clock_slow_i);
endmodule : strap_pins_assertions

bind strap_pins strap_pins_assertions u_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .local_power_sense_i(local_power_sense_i),
  .upstream_bus_power_sense_i(upstream_bus_power_sense_i), .clock_slow_i(clock_slow_i),
  .susp_clk_oe_o(susp_clk_oe_o), .ind_pin_oe_o(ind_pin_oe_o),
  .power_enable_port1_n_oe_o(power_enable_port1_n_oe_o),
  .power_enable_port2_n_o(power_enable_port2_n_o),
  .power_enable_port2_n_oe_o(power_enable_port2_n_oe_o),
  .compound_clock_out_o(compound_clock_out_o), .self_powered_o(self_powered_o),
  .upstream_present_o(upstream_present_o), .overcurrent_o(overcurrent_o),
  .overcurrent_event_o(overcurrent_event_o), .removable_o(removable_o),
  .individual_power_o(individual_power_o), .config_done_o(config_done_o));

// >>> bench/board_model.sv
/* Board model: strap resistors, power switches with fault flags.
   Assumes pin drive pairs come straight from strap_pins. */
`timescale 1ns/10ps
module board_model
  import strap_pins_pkg::*;
(
  input  wire strap_t     strap_i, // Resistor levels
  input  wire logic [1:0] fault_i, // Switch fault per port
  input  wire pin_drv_t   ind_i,   // Indicator pin drive
  input  wire pin_drv_t   pwr1_i,  // Port 1 power pin drive
  input  wire pin_drv_t   pwr2_i,  // Port 2 power pin drive
  output logic [1:0]      oc_o,    // Over-current lines
  output logic            ind1_o,  // Indicator pin level
  output logic            pwr1_o,  // Port 1 power pin level
  output logic            pwr2_o,  // Port 2 power pin level
  output logic [1:0]      vbus_o   // Switch outputs on
);
  // Released pins fall back to their resistor
  assign ind1_o = ind_i.oe ? ind_i.o : strap_i.ind_port1;
  assign pwr1_o = pwr1_i.oe ? pwr1_i.o : strap_i.pwr_port1;
  assign pwr2_o = pwr2_i.oe ? pwr2_i.o : strap_i.pwr_port2;
  // Fault flag pulls the over-current line low
  assign oc_o = {strap_i.oc_port2, strap_i.oc_port1} & ~fault_i;
  // Switch on while its enable is pulled low
  assign vbus_o = {pwr2_i.oe & ~pwr2_i.o, pwr1_i.oe & ~pwr1_i.o};
endmodule : board_model

// >>> bench/tb_top.sv
/* Bench for strap_pins: boots five strap setups, checks pin functions.
   Assumes board_model and the bound checker. */
`timescale 1ns/10ps
module tb_top import strap_pins_pkg::*;;
  logic sys_clk_i, srst_i, suspended_i, rom_use_clock_i, rom_suspend_en_i, clock_slow_i;
  logic dock_vbus_on_i, dock_id_on_i, compound_reset_req_i, local_power_sense_i;
  logic upstream_bus_power_sense_i, ind1_pin, pwr1_pin, pwr2_pin;
  logic susp_clk_o, susp_clk_oe_o, ind_pin_o, ind_pin_oe_o, power_enable_port1_n_o;
  logic power_enable_port1_n_oe_o, power_enable_port2_n_o, power_enable_port2_n_oe_o;
  logic compound_clock_out_o, self_powered_o, upstream_present_o, individual_power_o;
  logic config_done_o;
  logic [1:0] port_power_req_i, fault, oc_pin, vbus, overcurrent_o, overcurrent_event_o;
  logic [1:0] removable_o;
  strap_t straps;
  int miscompares, compares;
  // ---------------------------------------------------------------
  // Board and block
  // ---------------------------------------------------------------
  board_model u_board (.strap_i(straps), .fault_i(fault), .ind_i({ind_pin_o, ind_pin_oe_o}),
    .pwr1_i({power_enable_port1_n_o, power_enable_port1_n_oe_o}),
    .pwr2_i({power_enable_port2_n_o, power_enable_port2_n_oe_o}), .oc_o(oc_pin),
    .ind1_o(ind1_pin), .pwr1_o(pwr1_pin), .pwr2_o(pwr2_pin), .vbus_o(vbus));
  strap_pins dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .rom_select_strap_i(straps.rom_select), .overcurrent_in_port1_i(oc_pin[0]),
    .overcurrent_in_port2_i(oc_pin[1]), .indicator_pin_port1_i(ind1_pin),
    .indicator_pin_port2_i(straps.ind_port2), .power_enable_port1_n_i(pwr1_pin),
    .power_enable_port2_n_i(pwr2_pin), .upstream_bus_power_sense_i(upstream_bus_power_sense_i),
    .local_power_sense_i(local_power_sense_i), .suspended_i(suspended_i),
    .rom_use_clock_i(rom_use_clock_i), .rom_suspend_en_i(rom_suspend_en_i),
    .clock_slow_i(clock_slow_i), .port_power_req_i(port_power_req_i),
    .dock_vbus_on_i(dock_vbus_on_i), .dock_id_on_i(dock_id_on_i),
    .compound_reset_req_i(compound_reset_req_i), .susp_clk_o(susp_clk_o),
    .susp_clk_oe_o(susp_clk_oe_o), .ind_pin_o(ind_pin_o), .ind_pin_oe_o(ind_pin_oe_o),
    .power_enable_port1_n_o(power_enable_port1_n_o),
    .power_enable_port1_n_oe_o(power_enable_port1_n_oe_o),
    .power_enable_port2_n_o(power_enable_port2_n_o),
    .power_enable_port2_n_oe_o(power_enable_port2_n_oe_o),
    .compound_clock_out_o(compound_clock_out_o), .self_powered_o(self_powered_o),
    .upstream_present_o(upstream_present_o), .overcurrent_o(overcurrent_o),
    .overcurrent_event_o(overcurrent_event_o), .removable_o(removable_o),
    .individual_power_o(individual_power_o), .config_done_o(config_done_o));
  // Helpers: compare, edge step, verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : step
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Reset, then wait for pins to go live
  task automatic boot(input strap_t s);
    int n;
    straps = s;
    fault = 2'h0;
    srst_i = 1'b1;
    step(8);
    chk({susp_clk_oe_o, ind_pin_oe_o, power_enable_port1_n_oe_o, config_done_o}, 8'h00);
    chk(power_enable_port2_n_oe_o, 8'h00);
    srst_i = 1'b0;
    step(3);
    straps.rom_select = ~s.rom_select;
    n = 3;
    while (config_done_o !== 1'b1 && n < 800) begin
      step(1);
      n++;
    end
    if (n >= 800) begin
      miscompares++;
      test_done();
    end
    chk(8'(n >= STRAP_HOLD_CYC && n <= STRAP_HOLD_CYC + 2), 8'h01);
    step(2);
  endtask : boot
  task automatic count_rises(input int exp);
    int r;
    logic p;
    r = 0;
    p = compound_clock_out_o;
    repeat (100) begin
      step(1);
      if (!p && compound_clock_out_o) r++;
      p = compound_clock_out_o;
    end
    chk(8'(r), 8'(exp));
  endtask : count_rises
  // Suspend pin, individual power, over-current cut
  task automatic cfg_suspend();
    boot(strap_t'(7'h3F));
    chk({removable_o, individual_power_o}, 8'h07);
    suspended_i = 1'b1;
    step(2);
    chk({susp_clk_oe_o, susp_clk_o, ind_pin_oe_o}, 8'h06);
    suspended_i = 1'b0;
    port_power_req_i = 2'h1;
    step(2);
    chk({vbus, susp_clk_oe_o, susp_clk_o}, 8'h06);
    port_power_req_i = 2'h3;
    local_power_sense_i = 1'b0;
    upstream_bus_power_sense_i = 1'b0;
    step(2);
    chk({vbus, self_powered_o, upstream_present_o}, 8'h0C);
    fault = 2'h2;
    step(1);
    chk({overcurrent_o, overcurrent_event_o}, 8'h0A);
    step(1);
    chk({vbus, overcurrent_event_o}, 8'h04);
    fault = 2'h0;
    local_power_sense_i = 1'b1;
    upstream_bus_power_sense_i = 1'b1;
  endtask : cfg_suspend
  // Compound clock slow, compound reset, ganged power
  task automatic cfg_compound();
    clock_slow_i = 1'b1;
    boot(strap_t'(7'h1C));
    chk({power_enable_port1_n_oe_o, power_enable_port1_n_o}, 8'h02);
    step(NRD_RST_CYC);
    chk({power_enable_port1_n_oe_o, power_enable_port1_n_o}, 8'h03);
    compound_reset_req_i = 1'b1;
    step(2);
    chk({power_enable_port1_n_oe_o, power_enable_port1_n_o}, 8'h02);
    compound_reset_req_i = 1'b0;
    chk({removable_o, individual_power_o, susp_clk_oe_o}, 8'h09);
    count_rises(5);
    port_power_req_i = 2'h1;
    fault = 2'h1;
    step(2);
    chk({vbus[1], overcurrent_o}, 8'h04);
    fault = 2'h2;
    step(2);
    chk(vbus[1], 8'h00);
  endtask : cfg_compound
  // Dock mode on both shared pins
  task automatic cfg_dock();
    boot(strap_t'(7'h37));
    dock_vbus_on_i = 1'b1;
    dock_id_on_i = 1'b1;
    step(2);
    chk({susp_clk_oe_o, susp_clk_o, ind_pin_oe_o, ind_pin_o}, 8'h0B);
    dock_vbus_on_i = 1'b0;
    dock_id_on_i = 1'b0;
    step(2);
    chk({susp_clk_oe_o, susp_clk_o, ind_pin_oe_o, ind_pin_o}, 8'h02);
  endtask : cfg_dock
  // ROM picks clock, suspend on indicator pin
  task automatic cfg_rom_clock();
    clock_slow_i = 1'b0;
    rom_use_clock_i = 1'b1;
    rom_suspend_en_i = 1'b1;
    boot(strap_t'(7'h7F));
    count_rises(10);
    suspended_i = 1'b1;
    step(2);
    chk({susp_clk_oe_o, ind_pin_oe_o, ind_pin_o}, 8'h07);
    suspended_i = 1'b0;
    step(2);
    chk({ind_pin_oe_o, ind_pin_o}, 8'h02);
  endtask : cfg_rom_clock
  // Reserved indicator combination, never dock with ROM
  task automatic cfg_reserved();
    rom_use_clock_i = 1'b0;
    boot(strap_t'(7'h73));
    suspended_i = 1'b1;
    step(2);
    chk({susp_clk_oe_o, susp_clk_o, ind_pin_oe_o}, 8'h06);
  endtask : cfg_reserved
  // Clock and main sequence
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    {suspended_i, rom_use_clock_i, rom_suspend_en_i, clock_slow_i} = 4'h0;
    {dock_vbus_on_i, dock_id_on_i, compound_reset_req_i} = 3'h0;
    {local_power_sense_i, upstream_bus_power_sense_i, srst_i} = 3'h7;
    port_power_req_i = 2'h0;
    fault = 2'h0;
    straps = strap_t'(7'h3F);
    miscompares = 0;
    compares = 0;
    cfg_suspend();
    cfg_compound();
    cfg_dock();
    cfg_rom_clock();
    cfg_reserved();
    test_done();
  end
endmodule : tb_top
